// File: design/asp_axis_top.sv
// Axis speed-pattern controller with AHB-Lite register slave
`timescale 1ns/10ps
`include "asp_defines.svh"
module asp_axis_top
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // AHB-Lite slave
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic [31:0]            hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  // Motor driver
  output logic                   pulse_out,
  output logic                   direction_out,
  output logic                   busy_out,
  output asp_pkg::asp_phase_e    phase_out
);
  import asp_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  logic [7:0]  wr_addr;
  logic        wr_pend;
  wire         addr_ok  = hsel_in & hready_in & (htrans_in == `ASP_HTRANS_NONSEQ);
  wire         rd_take  = addr_ok & ~hwrite_in;
  wire  [31:0] wd       = hwdata_in;
  wire         wr_feed  = wr_pend & (wr_addr == `ASP_OFS_FEED);
  wire         wr_init  = wr_pend & (wr_addr == `ASP_OFS_INIT);
  wire         wr_oper  = wr_pend & (wr_addr == `ASP_OFS_OPER);
  wire         wr_accr  = wr_pend & (wr_addr == `ASP_OFS_ACCR);
  wire         wr_decr  = wr_pend & (wr_addr == `ASP_OFS_DECR);
  wire         wr_scale = wr_pend & (wr_addr == `ASP_OFS_SCALE);
  wire         wr_slow  = wr_pend & (wr_addr == `ASP_OFS_SLOW);
  wire         wr_sacc  = wr_pend & (wr_addr == `ASP_OFS_SACC);
  wire         wr_sdec  = wr_pend & (wr_addr == `ASP_OFS_SDEC);
  wire         wr_mode  = wr_pend & (wr_addr == `ASP_OFS_MODE);
  wire         wr_cmd   = wr_pend & (wr_addr == `ASP_OFS_CMD);

  // Pre-registers: hold their value until rewritten, so unchanged values need no rewrite
  logic [27:0] feed_amount_pre;
  logic [13:0] initial_speed_pre;
  logic [13:0] operating_speed_pre;
  logic [13:0] accel_rate_pre;
  logic [13:0] decel_rate_pre;
  logic [11:0] speed_scale_pre;
  logic [23:0] slowdown_point_pre;
  logic [12:0] scurve_accel_span_pre;
  logic [12:0] scurve_decel_span_pre;
  logic [1:0]  operation_mode_pre;

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      wr_pend               <= 1'b0;
      wr_addr               <= 8'h00;
      feed_amount_pre       <= 28'h0000000;
      initial_speed_pre     <= 14'h0001;
      operating_speed_pre   <= 14'h0001;
      accel_rate_pre        <= 14'h0001;
      decel_rate_pre        <= 14'h0000;
      speed_scale_pre       <= 12'h001;
      slowdown_point_pre    <= 24'h000000;
      scurve_accel_span_pre <= 13'h0000;
      scurve_decel_span_pre <= 13'h0000;
      operation_mode_pre    <= 2'h0;
    end
    else
    begin
      wr_pend <= addr_ok & hwrite_in;
      wr_addr <= haddr_in[7:0];
      // Upper bits beyond each width are dropped on write
      if (wr_feed)  feed_amount_pre       <= wd[27:0];
      if (wr_init)  initial_speed_pre     <= wd[13:0];
      if (wr_oper)  operating_speed_pre   <= wd[13:0];
      if (wr_accr)  accel_rate_pre        <= wd[13:0];
      if (wr_decr)  decel_rate_pre        <= wd[13:0];
      if (wr_scale) speed_scale_pre       <= wd[11:0];
      if (wr_slow)  slowdown_point_pre    <= wd[23:0];
      if (wr_sacc)  scurve_accel_span_pre <= wd[12:0];
      if (wr_sdec)  scurve_decel_span_pre <= wd[12:0];
      if (wr_mode)  operation_mode_pre    <= wd[1:0];
    end
  end

  // ****************************************
  // Working registers and motion state
  // ****************************************
  asp_phase_e  state;
  asp_phase_e  next_state;
  logic [13:0] initial_speed_work;
  logic [13:0] operating_speed_work;
  logic [13:0] accel_rate_work;
  logic [13:0] decel_rate_work;
  logic [11:0] speed_scale_work;
  logic [23:0] slowdown_point_work;
  logic [12:0] scurve_accel_span_work;
  logic [12:0] scurve_decel_span_work;
  logic        curve_shape_select;
  logic        slowdown_method_select;
  logic [27:0] remaining;
  logic [27:0] accel_pulses;
  logic [13:0] cur_speed;
  logic [15:0] unit_cnt;
  logic        half_step;
  logic        rate_pulse;

  wire         cmd_start = wr_cmd & wd[`ASP_CMD_START] & (state == ASP_IDLE);
  wire         cmd_stop  = wr_cmd & wd[`ASP_CMD_STOP];
  wire  [1:0]  cmd_code  = wd[1:0];
  wire         cmd_hs1   = (cmd_code == `ASP_HS1_CODE);
  wire  [27:0] feed_abs  = feed_amount_pre[27] ? (28'h0000000 - feed_amount_pre) : feed_amount_pre;
  wire         ramp_cmd  = cmd_code[1];

  // Effective rate and span for the current ramp direction
  wire         decel_ph  = (state == ASP_DECEL);
  wire  [13:0] decel_eff = (decel_rate_work == 14'h0000) ? accel_rate_work : decel_rate_work;
  wire  [13:0] rate_eff  = decel_ph ? decel_eff : accel_rate_work;
  wire  [16:0] unit_len  = {1'b0, ({1'b0, rate_eff} + 15'h0001), 1'b0};
  wire  [13:0] diff      = operating_speed_work - initial_speed_work;
  wire  [12:0] half_diff = diff[13:1];
  wire  [12:0] span_raw  = decel_ph ? scurve_decel_span_work : scurve_accel_span_work;
  wire  [12:0] span_lim  = (span_raw > half_diff) ? half_diff : span_raw;
  wire  [12:0] span_eff  = (span_raw == 13'h0000) ? half_diff : span_lim;
  wire  [13:0] dist_lo   = cur_speed - initial_speed_work;
  wire  [13:0] dist_hi   = operating_speed_work - cur_speed;
  wire         s_acc     = (dist_lo < {1'b0, span_eff}) | (dist_hi <= {1'b0, span_eff});
  wire         s_dec     = (dist_hi < {1'b0, span_eff}) | (dist_lo <= {1'b0, span_eff});
  // S regions take two units per speed step, linear ones take one
  wire         in_s      = curve_shape_select & (decel_ph ? s_dec : s_acc);
  wire         unit_end  = ({1'b0, unit_cnt} == unit_len - 17'h00001);
  wire         step      = unit_end & (~in_s | half_step);

  // Deceleration start decision
  wire  [29:0] auto_pt   = {2'b00, accel_pulses} + {{6{slowdown_point_work[23]}}, slowdown_point_work};
  wire         auto_hit  = $signed({2'b00, remaining}) <= $signed(auto_pt);
  wire         man_hit   = ({4'h0, slowdown_point_work} >= remaining);
  wire         slow_hit  = slowdown_method_select ? man_hit : auto_hit;
  wire         ramping   = (state == ASP_ACCEL) | (state == ASP_CRUISE);
  wire         last_pls  = rate_pulse & (remaining == 28'h0000001);
  wire         hs1_zero  = cmd_hs1 & (slowdown_point_pre == 24'h000000);
  wire         turn_down = (state == ASP_ACCEL) & (next_state == ASP_DECEL);

  always_comb
  begin
    next_state = state;
    case (state)
      ASP_IDLE:
        if (cmd_start & ~hs1_zero & (feed_abs != 28'h0000000))
          next_state = ramp_cmd ? ASP_ACCEL : (cmd_code[0] ? ASP_CRUISE : ASP_LOW);
      ASP_ACCEL:
        if (slow_hit)
          next_state = ASP_DECEL;
        else if (step & (cur_speed + 14'h0001 >= operating_speed_work))
          next_state = ASP_CRUISE;
      ASP_CRUISE:
        if (slow_hit & (cur_speed != initial_speed_work))
          next_state = ASP_DECEL;
      ASP_DECEL:
        if (step & (cur_speed - 14'h0001 <= initial_speed_work))
          next_state = ASP_LOW;
      ASP_LOW:
        next_state = ASP_LOW;
      default:
        next_state = ASP_IDLE;
    endcase
    // Positioning ends on the last pulse whatever the speed
    if ((state != ASP_IDLE) & (last_pls | cmd_stop))
      next_state = ASP_IDLE;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state                  <= ASP_IDLE;
      initial_speed_work     <= 14'h0001;
      operating_speed_work   <= 14'h0001;
      accel_rate_work        <= 14'h0001;
      decel_rate_work        <= 14'h0000;
      speed_scale_work       <= 12'h001;
      slowdown_point_work    <= 24'h000000;
      scurve_accel_span_work <= 13'h0000;
      scurve_decel_span_work <= 13'h0000;
      curve_shape_select     <= 1'b0;
      slowdown_method_select <= 1'b0;
      remaining              <= 28'h0000000;
      direction_out          <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (cmd_start)
      begin
        initial_speed_work     <= initial_speed_pre;
        operating_speed_work   <= operating_speed_pre;
        accel_rate_work        <= accel_rate_pre;
        decel_rate_work        <= decel_rate_pre;
        speed_scale_work       <= speed_scale_pre;
        slowdown_point_work    <= slowdown_point_pre;
        scurve_accel_span_work <= scurve_accel_span_pre;
        scurve_decel_span_work <= scurve_decel_span_pre;
        curve_shape_select     <= operation_mode_pre[`ASP_MODE_CURVE];
        slowdown_method_select <= operation_mode_pre[`ASP_MODE_METHOD] | cmd_hs1;
        remaining              <= feed_abs;
        direction_out          <= feed_amount_pre[27];
      end
      else if (rate_pulse & (remaining != 28'h0000000))
        remaining <= remaining - 28'h0000001;
    end
  end

  // Speed ramp: one unit lasts (rate+1)*2 clocks
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      cur_speed    <= 14'h0001;
      unit_cnt     <= 16'h0000;
      half_step    <= 1'b0;
      accel_pulses <= 28'h0000000;
    end
    else if (cmd_start)
    begin
      cur_speed    <= (cmd_code == ASP_CMD_HIGH_CONST) ? operating_speed_pre : initial_speed_pre;
      unit_cnt     <= 16'h0000;
      half_step    <= 1'b0;
      accel_pulses <= 28'h0000000;
    end
    // A unit begun at the accel rate must not overrun a shorter decel unit
    else if (turn_down)
    begin
      unit_cnt  <= 16'h0000;
      half_step <= 1'b0;
    end
    else if ((state == ASP_ACCEL) | decel_ph)
    begin
      unit_cnt  <= unit_end ? 16'h0000 : unit_cnt + 16'h0001;
      half_step <= unit_end ? (in_s & ~half_step) : half_step;
      if (step)
        cur_speed <= decel_ph ? cur_speed - 14'h0001 : cur_speed + 14'h0001;
      if ((state == ASP_ACCEL) & rate_pulse)
        accel_pulses <= accel_pulses + 28'h0000001;
    end
    else
    begin
      unit_cnt  <= 16'h0000;
      half_step <= 1'b0;
    end
  end

  asp_rate_gen u_rate
  (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .run_in    (state != ASP_IDLE),
    .speed_in  (cur_speed),
    .scale_in  (speed_scale_work),
    .pulse_out (rate_pulse)
  );

  // ****************************************
  // Read path and outputs
  // ****************************************
  wire [7:0]  ra      = haddr_in[7:0];
  wire [31:0] stat_w  = {2'b00, cur_speed, 12'h000, state, (state != ASP_IDLE)};
  wire [31:0] rd_mux  =
    (ra == `ASP_OFS_FEED)   ? {4'h0, feed_amount_pre} :
    (ra == `ASP_OFS_INIT)   ? {18'h00000, initial_speed_pre} :
    (ra == `ASP_OFS_OPER)   ? {18'h00000, operating_speed_pre} :
    (ra == `ASP_OFS_ACCR)   ? {18'h00000, accel_rate_pre} :
    (ra == `ASP_OFS_DECR)   ? {18'h00000, decel_rate_pre} :
    (ra == `ASP_OFS_SCALE)  ? {20'h00000, speed_scale_pre} :
    (ra == `ASP_OFS_SLOW)   ? {8'h00, slowdown_point_pre} :
    (ra == `ASP_OFS_SACC)   ? {19'h00000, scurve_accel_span_pre} :
    (ra == `ASP_OFS_SDEC)   ? {19'h00000, scurve_decel_span_pre} :
    (ra == `ASP_OFS_MODE)   ? {30'h00000000, operation_mode_pre} :
    (ra == `ASP_OFS_STAT)   ? stat_w :
    (ra == `ASP_OFS_REMAIN) ? {4'h0, remaining} : `ASP_ZERO32;

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      hrdata_out    <= `ASP_ZERO32;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      pulse_out     <= 1'b0;
      busy_out      <= 1'b0;
      phase_out     <= ASP_IDLE;
    end
    else
    begin
      hrdata_out    <= rd_take ? rd_mux : hrdata_out;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      pulse_out     <= rate_pulse & (state != ASP_IDLE);
      busy_out      <= (next_state != ASP_IDLE);
      phase_out     <= next_state;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [17:0] gap_cnt;
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || cmd_start || (state != $past(state)) || (cur_speed != $past(cur_speed)))
      gap_cnt <= 18'h00001;
    else
      gap_cnt <= gap_cnt + 18'h00001;
  end

  a_work_load_copy: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cmd_start |=> (initial_speed_work == $past(initial_speed_pre)) && (accel_rate_work == $past(accel_rate_pre)))
    else $error("working registers not loaded at start");

  a_accel_step_len: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == ASP_ACCEL) && !curve_shape_select && step && !slow_hit && !cmd_stop && !last_pls
    |-> gap_cnt + 18'h00001 == {3'h0, accel_rate_work, 1'b0} + 18'h00002)
    else $error("linear acceleration step length wrong");

  a_decel_rate_used: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == ASP_DECEL) && !curve_shape_select && step && !cmd_stop && !last_pls |->
      gap_cnt + 18'h00001 == {3'h0, ((decel_rate_work == 14'h0000) ? accel_rate_work : decel_rate_work), 1'b0}
      + 18'h00002)
    else $error("deceleration unit length does not follow decel rate");

  a_manual_slow_go: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ramping && slowdown_method_select && ({4'h0, slowdown_point_work} >= remaining) && !cmd_stop && !last_pls
    && (cur_speed != initial_speed_work) |=> state == ASP_DECEL)
    else $error("manual slowdown point did not start deceleration");

  a_auto_slow_go: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ramping && !slowdown_method_select && auto_hit && !cmd_stop && !last_pls && (cur_speed != initial_speed_work)
    |=> state == ASP_DECEL)
    else $error("automatic slowdown point did not start deceleration");

  a_low_hold_speed: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == ASP_LOW) && $past(state == ASP_DECEL) |-> cur_speed == initial_speed_work)
    else $error("low-speed tail not at initial speed");

  a_hs1_zero_stop: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cmd_start && hs1_zero |=> (state == ASP_IDLE) [*2])
    else $error("high-speed start with zero slowdown did not stop");

  a_write_mask_init: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_init |=> initial_speed_pre == $past(hwdata_in[13:0]))
    else $error("initial speed write not truncated to 14 bits");

  a_pulse_only_run: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pulse_out |-> $past(state) != ASP_IDLE)
    else $error("pulse emitted while idle");

  a_speed_in_band: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == ASP_ACCEL) |-> (cur_speed >= initial_speed_work) && (cur_speed <= operating_speed_work))
    else $error("speed outside initial to operating band");

endmodule : asp_axis_top

// File: design/asp_defines.svh
// Constants for the axis speed-pattern block: offsets, field positions, widths and codes
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ASP_OFS_FEED      8'h00
`define ASP_OFS_INIT      8'h04
`define ASP_OFS_OPER      8'h08
`define ASP_OFS_ACCR      8'h0C
`define ASP_OFS_DECR      8'h10
`define ASP_OFS_SCALE     8'h14
`define ASP_OFS_SLOW      8'h18
`define ASP_OFS_SACC      8'h1C
`define ASP_OFS_SDEC      8'h20
`define ASP_OFS_MODE      8'h24
`define ASP_OFS_CMD       8'h28
`define ASP_OFS_STAT      8'h2C
`define ASP_OFS_REMAIN    8'h30

// ****************************************
// Field positions, widths and codes
// ****************************************
`define ASP_W_FEED        28
`define ASP_W_SPEED       14
`define ASP_W_SCALE       12
`define ASP_W_SLOW        24
`define ASP_W_SPAN        13
`define ASP_MODE_CURVE    0
`define ASP_MODE_METHOD   1
`define ASP_CMD_START     2
`define ASP_CMD_STOP      3
`define ASP_HTRANS_NONSEQ 2'h2
`define ASP_ZERO32        32'h0000_0000
`define ASP_PRESCALE_W    12
`define ASP_HS1_CODE      2'h2

`endif

// File: design/asp_pkg.sv
// Types shared by the axis speed-pattern block
package asp_pkg;

  typedef enum logic [2:0] {
    ASP_IDLE,
    ASP_ACCEL,
    ASP_CRUISE,
    ASP_DECEL,
    ASP_LOW
  } asp_phase_e;

  typedef enum logic [1:0] {
    ASP_CMD_LOW_CONST,
    ASP_CMD_HIGH_CONST,
    ASP_CMD_HIGH_RAMP1,
    ASP_CMD_HIGH_RAMP2
  } asp_cmd_e;

endpackage : asp_pkg

// File: design/asp_rate_gen.sv
// Pulse-rate generator: speed times clock over ((scale+1) times 16384)
`timescale 1ns/10ps
module asp_rate_gen
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Rate control
  input  wire logic        run_in,
  input  wire logic [13:0] speed_in,
  input  wire logic [11:0] scale_in,
  // Pulse
  output logic             pulse_out
);

  logic [11:0] prescale;
  logic [13:0] phase_acc;
  wire         tick;
  wire  [14:0] sum;

  // One tick every scale+1 clocks, then a 14-bit phase accumulator adds the speed and pulses when it passes 16384
  assign tick = (prescale == scale_in);
  assign sum  = {1'b0, phase_acc} + {1'b0, speed_in};

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || !run_in)
    begin
      prescale  <= 12'h000;
      phase_acc <= 14'h0000;
      pulse_out <= 1'b0;
    end
    else
    begin
      prescale  <= tick ? 12'h000 : prescale + 12'h001;
      phase_acc <= tick ? sum[13:0] : phase_acc;
      pulse_out <= tick & sum[14];
    end
  end

endmodule : asp_rate_gen

// File: verification/asp_motor_model.sv
// Motor driver model: counts step pulses and latches direction
`timescale 1ns/10ps
module asp_motor_model
(
  // Clock
  input  wire logic        clk_in,
  // Step interface
  input  wire logic        pulse_in,
  input  wire logic        direction_in,
  // Observed
  output logic [31:0]      steps_out,
  output logic             dir_out
);
  initial
  begin
    steps_out = 32'h0;
    dir_out   = 1'b0;
  end

  // A step is one high sample; direction must be valid with it
  always @(posedge clk_in)
    if (pulse_in === 1'b1)
    begin
      steps_out <= steps_out + 32'h1;
      dir_out   <= direction_in;
    end
endmodule : asp_motor_model

// File: verification/asp_tb.sv
// Testbench for the axis speed-pattern controller
`timescale 1ns/10ps
`include "asp_defines.svh"
module testbench;
  import asp_pkg::*;
  logic               clk_in;
  logic               rstn_in;
  logic               hsel_in;
  logic               hwrite_in;
  logic [31:0]        haddr_in;
  logic [31:0]        hwdata_in;
  logic [1:0]         htrans_in;
  logic [2:0]         hsize_in;
  logic [31:0]        hrdata_out;
  logic               hreadyout_out;
  logic               hresp_out;
  logic               pulse_out;
  logic               direction_out;
  logic               busy_out;
  asp_phase_e         phase_out;
  logic [31:0]        steps;
  logic               dir_seen;
  int                 n_mismatch;
  int                 check_count;
  int                 n_acc;
  int                 n_dec;
  int                 n_low;

  asp_axis_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .pulse_out(pulse_out), .direction_out(direction_out),
    .busy_out(busy_out), .phase_out(phase_out));
  asp_motor_model motor (.clk_in(clk_in), .pulse_in(pulse_out), .direction_in(direction_out),
    .steps_out(steps), .dir_out(dir_seen));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ****************************************
  // Phase time counters
  // ****************************************
  always @(posedge clk_in)
  begin
    if (phase_out === ASP_ACCEL) n_acc <= n_acc + 1;
    if (phase_out === ASP_DECEL) n_dec <= n_dec + 1;
    if (phase_out === ASP_LOW) n_low <= n_low + 1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Read data is taken at the same edge at which ready is seen high
  task automatic wait_ready(output logic [31:0] rd);
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clk_in);
      if (hreadyout_out === 1'b1)
      begin
        rd = hrdata_out;
        return;
      end
    end
    n_mismatch++;
    close_out();
  endtask : wait_ready

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h000000, a};
    hwrite_in <= wr;
    htrans_in <= `ASP_HTRANS_NONSEQ;
    wait_ready(rd);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_ready(rd);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0, rd);
    chk(name, exp, rd);
    chk("response", 32'h0, {31'h0, hresp_out});
  endtask : rd_chk

  task automatic wait_idle;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 20000; i++)
    begin
      @(negedge clk_in);
      if (busy_out === 1'b0)
      begin
        // Two edges, so the model has counted the final step
        repeat (2) @(posedge clk_in);
        return;
      end
    end
    n_mismatch++;
    close_out();
  endtask : wait_idle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0]  a [9] = '{`ASP_OFS_INIT, `ASP_OFS_OPER, `ASP_OFS_ACCR, `ASP_OFS_DECR, `ASP_OFS_SCALE,
                           `ASP_OFS_SLOW, `ASP_OFS_SACC, `ASP_OFS_SDEC, `ASP_OFS_FEED};
    logic [31:0] m [9] = '{32'h3FFF, 32'h3FFF, 32'h3FFF, 32'h3FFF, 32'hFFF,
                           32'hFFFFFF, 32'h1FFF, 32'h1FFF, 32'hFFFFFFF};
    rd_chk("init reset", `ASP_OFS_INIT, 32'h1);
    rd_chk("decel reset", `ASP_OFS_DECR, 32'h0);
    rd_chk("scale reset", `ASP_OFS_SCALE, 32'h1);
    for (int i = 0; i < 9; i++)
    begin
      wr(a[i], 32'hFFFFFFFF);
      rd_chk("masked reg", a[i], m[i]);
    end
    wr(8'h40, 32'h12345678);
    rd_chk("unmapped", 8'h40, 32'h0);
    rd_chk("command", `ASP_OFS_CMD, 32'h0);
    wr(`ASP_OFS_SCALE, 32'h1);
    wr(`ASP_OFS_INIT, 32'hFA);
    wr(`ASP_OFS_OPER, 32'hFE);
    wr(`ASP_OFS_ACCR, 32'h1);
    wr(`ASP_OFS_DECR, 32'h0);
    wr(`ASP_OFS_SDEC, 32'h0);
  endtask : t_regs

  // Speed 250 to 254, far feed: acceleration finishes long before any step
  task automatic t_ramp(input logic [31:0] mode, input logic [31:0] span, input logic [31:0] exp);
    int a0;
    a0 = n_acc;
    wr(`ASP_OFS_MODE, mode);
    wr(`ASP_OFS_SACC, span);
    wr(`ASP_OFS_SLOW, 32'h0);
    wr(`ASP_OFS_FEED, 32'd1000);
    wr(`ASP_OFS_CMD, 32'h7);
    repeat (60) @(posedge clk_in);
    wr(`ASP_OFS_CMD, 32'h8);
    wait_idle();
    chk("accel time", exp, 32'(n_acc - a0));
  endtask : t_ramp

  task automatic t_decel(input logic [31:0] mode, input logic [31:0] dec, input logic [31:0] exp);
    int d0;
    int l0;
    logic [31:0] s0;
    d0 = n_dec;
    l0 = n_low;
    s0 = steps;
    wr(`ASP_OFS_MODE, mode);
    wr(`ASP_OFS_DECR, dec);
    wr(`ASP_OFS_SLOW, 32'h2);
    wr(`ASP_OFS_FEED, 32'h4);
    wr(`ASP_OFS_CMD, 32'h7);
    wait_idle();
    chk("decel time", exp, 32'(n_dec - d0));
    chk("low after decel", 32'h1, 32'(n_low > l0));
    chk("steps", 32'h4, steps - s0);
  endtask : t_decel

  task automatic t_hs1;
    logic [31:0] s0;
    s0 = steps;
    wr(`ASP_OFS_MODE, 32'h0);
    wr(`ASP_OFS_SLOW, 32'h0);
    wr(`ASP_OFS_CMD, 32'h6);
    repeat (5) @(posedge clk_in);
    chk("busy", 32'h0, {31'h0, busy_out});
    rd_chk("status busy", `ASP_OFS_STAT, 32'h00FA0000);
    chk("steps", s0, steps);
  endtask : t_hs1

  // Feed rewritten mid-move must not change the move in progress
  task automatic t_const;
    logic [31:0] s0;
    s0 = steps;
    wr(`ASP_OFS_FEED, 32'h0FFFFFFD);
    wr(`ASP_OFS_CMD, 32'h4);
    repeat (3) @(posedge clk_in);
    wr(`ASP_OFS_FEED, 32'd50);
    wait_idle();
    chk("steps", 32'h3, steps - s0);
    chk("direction", 32'h1, {31'h0, dir_seen});
    rd_chk("feed kept", `ASP_OFS_FEED, 32'd50);
  endtask : t_const

  initial
  begin
    {rstn_in, hsel_in, hwrite_in, htrans_in} = '0;
    {haddr_in, hwdata_in} = '0;
    hsize_in = 3'h2;
    {n_mismatch, check_count, n_acc, n_dec, n_low} = '0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_ramp(32'h0, 32'h0, 32'd16);
    t_ramp(32'h1, 32'h0, 32'd32);
    t_ramp(32'h1, 32'h1, 32'd24);
    t_decel(32'h2, 32'h0, 32'd16);
    t_decel(32'h2, 32'h3, 32'd32);
    t_decel(32'h0, 32'h0, 32'd16);
    t_hs1();
    t_const();
    close_out();
  end
endmodule : testbench
